// ===== logic/gpf_pin_ctrl.sv
// Function controller for one general-purpose pin: control register, pad
// drive, input routing to internal requests and the pin edge interrupt.
// Assumes the pad input is synchronous to aclk and the pad itself resolves
// out/oe and the pull controls.
//
// Summary of operation
// - Two-bit pull field: none, pull-down, pull-up, reserved; resets to pull-down.
// - Edge mode 0: interrupt on rising edge, or falling edge when inverted.
// - Edge mode 1: interrupt on both edges whatever the polarity.
// - Supply select bit, reset 0: buffer supply, 1 selects always-on supply.
// - Polarity bit, reset 1: 0 inverts the pin signal, 1 passes it.
// - Output drive push-pull when drive bit is 0, open-drain when 1.
// - Enable bit 0 tri-states the pin; direction bit resets to input.
// - Input codes 0 and 1: plain level with and without long debounce.
// - Input codes 2 to 6 route the pin to power and sleep requests.
// - Input code 7 watchdog reset; codes 8 and 9 voltage scaling selects.
// - Input codes 10 to 15: hardware enables and controls, some debounced.
// - Output code 0 drives the software level, code 1 the slow oscillator.
// - Output codes 2 to 4 show on, sleep and state change; 5 to 7 reserved.
// - Output codes 10 to 15: power enables, supply goods, fast clock, reset.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "gpf_cfg.svh"

module gpf_pin_ctrl
	import gpf_pkg::*;
#(
	parameter int unsigned LONG_DEB_CYCLES = `GPF_LONG_DEB_US * `GPF_CLK_MHZ,
	parameter int ADDR_W = `GPF_ADDR_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pin_in,
	input wire gpf_pkg::gpf_src_t status_src,
	output gpf_pkg::gpf_pad_t pad,
	output gpf_pkg::gpf_req_t req,
	output logic irq
);
	import gpf_pkg::*;

	// ======================================================================
	// Function code decoding
	function automatic logic fn_long_deb(input logic [3:0] fn);
		logic [15:0] sel;
		sel = 16'h0001 << fn;
		return (sel & `GPF_LONG_FN_MASK) != 16'h0;
	endfunction

	// ======================================================================
	// Bus front end
	logic wr_en, rd_en, wr_err, rd_err;
	logic [ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	gpf_reg_t wr_sel, rd_sel;

	gpf_axil_slave #(
		.ADDR_W(ADDR_W)
	) u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Decode from the held address so a new address cannot retarget a pending write
	assign wr_sel = gpf_decode(wr_addr);
	assign rd_sel = gpf_decode(rd_addr);
	// The level register is read-only, so a write to it is refused
	assign wr_err = (wr_sel == REG_NONE) || (wr_sel == REG_LEVEL);
	assign rd_err = (rd_sel == REG_NONE);

	// ======================================================================
	// Register state
	gpf_ctrl_t ctrl_ff, nxt_ctrl;
	logic sw_level_ff, nxt_sw_level;
	logic edge_stat_ff, nxt_edge_stat;
	logic edge_mask_ff, nxt_edge_mask;
	logic [15:0] ctrl_merged;

	// Byte lanes 0 and 1 carry the 16-bit control word
	always_comb begin
		ctrl_merged = ctrl_ff;
		if (wr_strb[0]) begin
			ctrl_merged[7:0] = wr_data[7:0];
		end
		if (wr_strb[1]) begin
			ctrl_merged[15:8] = wr_data[15:8];
		end
	end

	logic edge_evt;

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_sw_level = sw_level_ff;
		nxt_edge_mask = edge_mask_ff;
		nxt_edge_stat = edge_stat_ff;
		if (wr_en && wr_sel == REG_CTRL) begin
			// Masking at the write keeps reserved bits zero with no read-side mask
			nxt_ctrl = gpf_ctrl_t'(ctrl_merged & `GPF_CTRL_WMASK);
		end
		if (wr_en && wr_sel == REG_OUT && wr_strb[0]) begin
			nxt_sw_level = wr_data[0];
		end
		if (wr_en && wr_sel == REG_MASK && wr_strb[0]) begin
			nxt_edge_mask = wr_data[`GPF_STAT_EDGE];
		end
		// A read clears the sticky bit, but an edge in the same cycle survives
		if (rd_en && rd_sel == REG_STAT) begin
			nxt_edge_stat = 1'b0;
		end
		if (edge_evt) begin
			nxt_edge_stat = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= gpf_ctrl_t'(`GPF_CTRL_RESET);
			sw_level_ff <= 1'b0;
			edge_stat_ff <= 1'b0;
			edge_mask_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			sw_level_ff <= nxt_sw_level;
			edge_stat_ff <= nxt_edge_stat;
			edge_mask_ff <= nxt_edge_mask;
		end
	end

	// Level output: stays high until software reads status or clears the mask
	assign irq = edge_stat_ff && edge_mask_ff;

	// ======================================================================
	// Input path
	logic lvl_raw, lvl_deb, lvl_sel, lvl_prev_ff, nxt_lvl_prev;
	logic in_active, out_active;
	logic [15:0] fn_onehot;

	assign in_active = ctrl_ff.enable && ctrl_ff.dir;
	assign out_active = ctrl_ff.enable && !ctrl_ff.dir;
	// Requests are levels; a disabled or output pin routes nothing
	assign fn_onehot = 16'h0001 << ctrl_ff.func;
	// Logical level: inverted polarity means the pin is active low
	assign lvl_raw = pin_in ^ !ctrl_ff.pol;

	// The filter runs for every code, so a switch to a filtered code starts settled
	gpf_debounce #(
		.CYCLES(LONG_DEB_CYCLES)
	) u_long_deb (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(lvl_raw),
		.dout(lvl_deb)
	);

	// Codes 0, 4, 14 and 15 take the filtered level, the rest the direct one
	assign lvl_sel = fn_long_deb(ctrl_ff.func) ? lvl_deb : lvl_raw;

	// Edge events follow the level in use, so a long-debounced pin only
	// interrupts once the level has settled
	always_comb begin
		nxt_lvl_prev = lvl_sel;
		edge_evt = 1'b0;
		if (in_active) begin
			if (ctrl_ff.edge_mode) begin
				edge_evt = lvl_sel != lvl_prev_ff;
			end else begin
				edge_evt = lvl_sel && !lvl_prev_ff;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_prev_ff <= 1'b0;
		end else begin
			lvl_prev_ff <= nxt_lvl_prev;
		end
	end

	// ======================================================================
	// Request routing and pad drive
	gpf_req_t req_ff, nxt_req;
	gpf_pad_t pad_ff, nxt_pad;
	logic [15:0] out_src;
	logic out_val;

	// Output sources in function-code order; codes 5 to 7 drive inactive
	assign out_src = {
		status_src.aux_reset,
		status_src.ext_pwr_clk,
		status_src.converter_power_good,
		status_src.system_supply_good,
		status_src.ext_pwr_en_two,
		status_src.ext_pwr_en_one,
		status_src.dvs_done_two,
		status_src.dvs_done_one,
		3'b000,
		status_src.pwr_change,
		status_src.sleep_state,
		status_src.on_state,
		status_src.osc_32k,
		sw_level_ff
	};

	assign out_val = out_src[ctrl_ff.func] ^ !ctrl_ff.pol;

	always_comb begin
		nxt_req = gpf_req_t'(16'h0);
		if (in_active) begin
			nxt_req = gpf_req_t'(fn_onehot & {16{lvl_sel}});
		end
		nxt_pad.pull_down = ctrl_ff.pull == `GPF_PULL_DOWN;
		nxt_pad.pull_up = ctrl_ff.pull == `GPF_PULL_UP;
		nxt_pad.supply_sel = ctrl_ff.supply;
		nxt_pad.out = 1'b0;
		nxt_pad.oe = 1'b0;
		if (out_active) begin
			// Open drain never drives high: a one releases the pin to its pull
			if (ctrl_ff.drive) begin
				nxt_pad.oe = !out_val;
			end else begin
				nxt_pad.out = out_val;
				nxt_pad.oe = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_ff <= gpf_req_t'(16'h0);
			pad_ff <= '0;
		end else begin
			req_ff <= nxt_req;
			pad_ff <= nxt_pad;
		end
	end

	assign req = req_ff;
	assign pad = pad_ff;

	// ======================================================================
	// Read data
	// Decoded from the live read address; the slave registers it in the accept cycle
	always_comb begin
		rd_data = 32'h0;
		unique case (rd_sel)
			REG_CTRL: rd_data[15:0] = ctrl_ff;
			REG_OUT: rd_data[0] = sw_level_ff;
			REG_STAT: rd_data[`GPF_STAT_EDGE] = edge_stat_ff;
			REG_MASK: rd_data[`GPF_STAT_EDGE] = edge_mask_ff;
			REG_LEVEL: begin
				rd_data[`GPF_LVL_RAW] = lvl_raw;
				rd_data[`GPF_LVL_DEB] = lvl_deb;
				rd_data[`GPF_LVL_PIN] = pin_in;
			end
			REG_NONE: rd_data = 32'h0;
		endcase
	end

endmodule // gpf_pin_ctrl

// ===== logic/gpf_cfg.svh
// Constants of the pin function controller: register offsets, reset values,
// field codes and timing figures.
// Assumes a single 250 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef GPF_CFG_SVH
`define GPF_CFG_SVH

// ==========================================================================
// Register byte addresses
`define GPF_ADDR_W 16
`define GPF_ADDR_CTRL 16'h4038
`define GPF_ADDR_OUT 16'h403c
`define GPF_ADDR_STAT 16'h4040
`define GPF_ADDR_MASK 16'h4044
`define GPF_ADDR_LEVEL 16'h4048

// ==========================================================================
// Reset values and writable bits
`define GPF_CTRL_RESET 16'ha400
`define GPF_CTRL_WMASK 16'hfe8f
`define GPF_PULL_DOWN 2'b01
`define GPF_PULL_UP 2'b10
`define GPF_STAT_EDGE 0
`define GPF_LVL_RAW 0
`define GPF_LVL_DEB 1
`define GPF_LVL_PIN 2

// Function codes that use the long debounce filter: 0, 4, 14 and 15
`define GPF_LONG_FN_MASK 16'hc011

// ==========================================================================
// Timing
`define GPF_CLK_MHZ 250
`define GPF_LONG_DEB_US 1000

// ==========================================================================
// Bus responses
`define GPF_RESP_OKAY 2'b00
`define GPF_RESP_SLVERR 2'b10

`endif

// ===== logic/gpf_pkg.sv
// Types shared by the pin function controller, its port checker and its bench.
// Assumes gpf_cfg.svh is on the include path.
`include "gpf_cfg.svh"

package gpf_pkg;

	// ======================================================================
	// Control register layout, bit 15 down to bit 0
	typedef struct packed {
		logic dir;
		logic [1:0] pull;
		logic edge_mode;
		logic supply;
		logic pol;
		logic drive;
		logic rsv_8;
		logic enable;
		logic [2:0] rsv_6_4;
		logic [3:0] func;
	} gpf_ctrl_t;

	// Internal requests, one field per input function code, code 15 first
	typedef struct packed {
		logic hw_ctl_two_deb;
		logic hw_ctl_one_deb;
		logic hw_ctl_two;
		logic hw_ctl_one;
		logic hw_en_two;
		logic hw_en_one;
		logic voltage_scaling_select_two;
		logic voltage_scaling_select_one;
		logic watchdog_reset;
		logic power_on_req;
		logic sleep_req;
		logic sleep_wake_deb;
		logic sleep_wake;
		logic power_onoff;
		logic level_plain;
		logic level_deb;
	} gpf_req_t;

	// Internal states that an output pin may show
	typedef struct packed {
		logic aux_reset;
		logic ext_pwr_clk;
		logic converter_power_good;
		logic system_supply_good;
		logic ext_pwr_en_two;
		logic ext_pwr_en_one;
		logic dvs_done_two;
		logic dvs_done_one;
		logic pwr_change;
		logic sleep_state;
		logic on_state;
		logic osc_32k;
	} gpf_src_t;

	// Pad controls
	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic pull_down;
		logic supply_sel;
	} gpf_pad_t;

	typedef enum logic [2:0] {REG_CTRL, REG_OUT, REG_STAT, REG_MASK, REG_LEVEL, REG_NONE} gpf_reg_t;

	function automatic gpf_reg_t gpf_decode(input logic [`GPF_ADDR_W-1:0] a);
		case (a)
			`GPF_ADDR_CTRL: gpf_decode = REG_CTRL;
			`GPF_ADDR_OUT: gpf_decode = REG_OUT;
			`GPF_ADDR_STAT: gpf_decode = REG_STAT;
			`GPF_ADDR_MASK: gpf_decode = REG_MASK;
			`GPF_ADDR_LEVEL: gpf_decode = REG_LEVEL;
			default: gpf_decode = REG_NONE;
		endcase
	endfunction

endpackage

// ===== logic/gpf_debounce.sv
// Stability filter: the output follows the input only after the input has
// held one value for CYCLES consecutive clocks.
// Assumes the input is synchronous to aclk.
`timescale 1ns/1ps

module gpf_debounce #(
	parameter int unsigned CYCLES = 250000
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic din,
	output logic dout
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic level_ff;
	logic nxt_level;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	// ======================================================================
	// Any glitch restarts the count, so the level needs a full quiet interval
	always_comb begin
		nxt_level = level_ff;
		nxt_cnt = '0;
		if (din != level_ff) begin
			if (cnt_ff == LAST) begin
				nxt_level = din;
			end else begin
				nxt_cnt = cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_ff <= 1'b0;
			cnt_ff <= '0;
		end else begin
			level_ff <= nxt_level;
			cnt_ff <= nxt_cnt;
		end
	end

	assign dout = level_ff;

endmodule // gpf_debounce

// ===== logic/gpf_axil_slave.sv
// AXI4-Lite slave front end: turns bus transfers into one-cycle register
// write and read strobes.
// Assumes the register file answers reads combinationally in the strobe cycle.
`timescale 1ns/1ps
`include "gpf_cfg.svh"

module gpf_axil_slave #(
	parameter int ADDR_W = `GPF_ADDR_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_en,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	logic aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
	logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

	// ======================================================================
	// Handshakes: address and data are held separately, in either order
	assign s_axi_awready = !aw_full_ff;
	assign s_axi_wready = !w_full_ff;
	assign s_axi_arready = !rvalid_ff;
	assign wr_en = aw_full_ff && w_full_ff && !bvalid_ff;
	assign wr_addr = awaddr_ff;
	assign wr_data = wdata_ff;
	assign wr_strb = wstrb_ff;
	assign rd_en = s_axi_arvalid && !rvalid_ff;
	assign rd_addr = s_axi_araddr;

	always_comb begin
		nxt_aw_full = aw_full_ff;
		nxt_w_full = w_full_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff && !s_axi_bready;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff && !s_axi_rready;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_awvalid && !aw_full_ff) begin
			nxt_aw_full = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_full_ff) begin
			nxt_w_full = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (wr_en) begin
			nxt_aw_full = 1'b0;
			nxt_w_full = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = wr_err ? `GPF_RESP_SLVERR : `GPF_RESP_OKAY;
		end
		if (rd_en) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = rd_data;
			nxt_rresp = rd_err ? `GPF_RESP_SLVERR : `GPF_RESP_OKAY;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			w_full_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `GPF_RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= `GPF_RESP_OKAY;
		end else begin
			aw_full_ff <= nxt_aw_full;
			w_full_ff <= nxt_w_full;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

endmodule // gpf_axil_slave

// ===== verif/gpf_pin_ctrl_props.sv
// Port checker of the pin function controller.
// Assumes it is bound onto gpf_pin_ctrl; one clock domain only.
`timescale 1ns/1ps

module gpf_pin_ctrl_props
	import gpf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire gpf_pkg::gpf_pad_t pad,
	input wire gpf_pkg::gpf_req_t req,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ======================================================================
	// Bus handshakes
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped early");
	read_busy_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answered with no address taken");
	write_busy_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write answered before address and data were both held");

	// ======================================================================
	// Pad, requests and interrupt
	pull_excl_a: assert property (!(pad.pull_up && pad.pull_down))
		else $error("both pulls on");
	reset_pad_a: assert property ($rose(aresetn) |=> pad.pull_down && !pad.pull_up && !pad.oe && !pad.supply_sel)
		else $error("pad not at reset setting");
	req_single_a: assert property ($onehot0(req))
		else $error("more than one request routed");
	req_output_a: assert property (pad.oe |-> req == '0)
		else $error("request while pin drives");
	// Only a read of status or a register write may take the interrupt away
	irq_sticky_a: assert property ($fell(irq) |-> $past(s_axi_arvalid && s_axi_arready) || $rose(s_axi_bvalid))
		else $error("interrupt fell with no clearing access");

	cover property ($rose(irq));
	cover property (req.level_deb);
	cover property (pad.oe && !pad.out);
endmodule // gpf_pin_ctrl_props

// ===== verif/gpf_pin_partner.sv
// Model of the net on the pin: the pad, an outside driver or the pulls.
// Assumes pad.oe high means the pad drives; the net is sampled on aclk.
`timescale 1ns/1ps

module gpf_pin_partner
	import gpf_pkg::*;
(
	input wire logic aclk,
	input wire gpf_pkg::gpf_pad_t pad,
	input wire logic ext_en,
	input wire logic ext_lvl,
	output logic pin_in
);
	logic nxt_pin;

	always_comb begin
		if (pad.oe === 1'b1)
			nxt_pin = pad.out;
		else if (ext_en)
			nxt_pin = ext_lvl;
		else if (pad.pull_up === 1'b1)
			nxt_pin = 1'b1;
		else if (pad.pull_down === 1'b1)
			nxt_pin = 1'b0;
		else
			// Floating net toggles so a stale level can never pass
			nxt_pin = !pin_in;
	end

	initial pin_in = 1'b0;
	always @(posedge aclk) pin_in <= nxt_pin;
endmodule // gpf_pin_partner

// ===== verif/gpf_pin_ctrl_tb_top.sv
// Self-checking bench of the pin function controller.
// Assumes the pin net model and the bound port checker.
`timescale 1ns/1ps
`include "gpf_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end

module gpf_pin_ctrl_tb_top;
	import gpf_pkg::*;
	localparam int unsigned LONG = 8;
	localparam logic [15:0] LMASK = `GPF_LONG_FN_MASK;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [15:0] awaddr = '0;
	logic [15:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic ext_en = 1'b0;
	logic ext_lvl = 1'b0;
	gpf_src_t src = '0;
	logic awready, wready, bvalid, arready, rvalid, irq, pin_in;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	gpf_pad_t pad;
	gpf_req_t req;
	logic [31:0] seed = 32'h078a;
	int mismatches = 0;
	int n_compared = 0;

	gpf_pin_ctrl #(.LONG_DEB_CYCLES(LONG)) i_gpf_pin_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .status_src(src), .pad(pad), .req(req), .irq(irq));
	gpf_pin_partner i_gpf_pin_partner (.aclk(aclk), .pad(pad), .ext_en(ext_en), .ext_lvl(ext_lvl),
		.pin_in(pin_in));

	initial forever #2 aclk = !aclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic exp_edge(input logic mode, input logic pol, input logic rising);
		return mode || (rising == pol);
	endfunction

	function automatic logic exp_val(input logic [3:0] c, input logic [11:0] s, input logic o, input logic p);
		logic v;
		if (c == 4'h0)
			v = o;
		else if (c < 4'h5)
			v = s[c - 4'h1];
		else if (c < 4'h8)
			v = 1'b0;
		else
			v = s[c - 4'h4];
		return v ^ !p;
	endfunction

	// ======================================================================
	// Bus master; ready is looked at mid-cycle, where it is settled
	task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			done = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(negedge aclk);
			ta = arvalid && arready;
			done = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	task automatic wok(input logic [15:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		`CHK(r, `GPF_RESP_OKAY)
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge aclk);
	endtask

	task automatic finish_test;
		$display("TB: compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		finish_test();
	end

	// ======================================================================
	// Scenarios
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] cw;
		logic [3:0] c;
		logic p, dr, e;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`GPF_ADDR_CTRL, d, r);
		`CHK(d, 32'h0000a400)
		wok(`GPF_ADDR_CTRL, 32'hffffffff);
		rd(`GPF_ADDR_CTRL, d, r);
		`CHK(d, 32'h0000fe8f)
		rd(16'h4050, d, r);
		`CHK({r, d}, {`GPF_RESP_SLVERR, 32'h0})
		wr(`GPF_ADDR_LEVEL, 32'h1, r);
		`CHK(r, `GPF_RESP_SLVERR)
		// Debounced codes must still be low shortly after the pin moves
		ext_en <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			c = 4'(i);
			wok(`GPF_ADDR_CTRL, {16'h0, 12'h848, c});
			idle(2 * LONG);
			ext_lvl <= 1'b1;
			idle(3);
			`CHK(req, LMASK[i] ? 16'h0 : 16'h1 << i)
			idle(2 * LONG);
			`CHK(req, 16'h1 << i)
			ext_lvl <= 1'b0;
			idle(2 * LONG);
		end
		for (int i = 0; i < 8; i++) begin
			wok(`GPF_ADDR_MASK, {31'h0, i[2]});
			wok(`GPF_ADDR_CTRL, {16'h0, 3'b100, i[0], 1'b0, i[1], 10'h081});
			idle(4);
			rd(`GPF_ADDR_STAT, d, r);
			ext_lvl <= 1'b1;
			idle(4);
			`CHK(irq, exp_edge(i[0], i[1], 1'b1) & i[2])
			rd(`GPF_ADDR_STAT, d, r);
			`CHK(d[0], exp_edge(i[0], i[1], 1'b1))
			ext_lvl <= 1'b0;
			idle(4);
			rd(`GPF_ADDR_STAT, d, r);
			`CHK(d[0], exp_edge(i[0], i[1], 1'b0))
			idle(1);
			`CHK(irq, 1'b0)
		end
		ext_en <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			c = 4'(i);
			p = seed[0] | (c inside {[5:7]});
			dr = seed[1];
			cw = {1'b0, seed[3:2], 1'b0, seed[4], p, dr, 2'b01, 3'b000, c};
			wok(`GPF_ADDR_OUT, {31'h0, seed[5]});
			wok(`GPF_ADDR_CTRL, {16'h0, cw});
			src <= seed[17:6];
			idle(3);
			e = exp_val(c, seed[17:6], seed[5], p);
			`CHK(pad, {dr ? 1'b0 : e, dr ? !e : 1'b1, seed[3:2] == 2'b10, seed[3:2] == 2'b01, seed[4]})
			`CHK(req, 16'h0)
		end
		wok(`GPF_ADDR_CTRL, 32'h00000001);
		idle(3);
		`CHK(pad.oe, 1'b0)
		finish_test();
	end
endmodule // gpf_pin_ctrl_tb_top

bind gpf_pin_ctrl gpf_pin_ctrl_props i_gpf_pin_ctrl_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pad(pad), .req(req), .irq(irq));
